// [src/sram_port_defs.svh]
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

// array geometry
`define ADDR_W          19
`define DATA_W          32
`define LANES           4
`define WORDS           524288
`define BURST_W         2

// reset values
`define STEP_RESET      2'h0
`define BASE_RESET      2'h0

// sleep timing, in clock periods of the 8 ns clock
`define SLEEP_ENTRY_TIME_CYC     2
`define SLEEP_RECOVERY_TIME_CYC  2

// read buffer depth
`define RDBUF_DEPTH     2

`endif

// [src/sram_port_pkg.sv]
`include "sram_port_defs.svh"

package sram_port_pkg;

    // one read word on its way to the data pins
    typedef struct packed {
        logic                 drive;
        logic [`DATA_W-1:0]   data;
    } rd_word_s;

    // whole state of the port
    typedef struct packed {
        logic                        sync1;
        logic                        asleep;
        logic                        burst_active;
        logic                        deselected;
        logic [`ADDR_W-1:`BURST_W]   upper;
        logic [`BURST_W-1:0]         base;
        logic [`BURST_W-1:0]         step;
        logic [`ADDR_W-1:0]          addr_r;
        logic                        rd_go;
        logic                        rd_drive;
    } port_state_s;

endpackage

// [src/read_buffer.sv]
`timescale 1ns/1ps
`default_nettype none

module read_buffer #(
    parameter int W = 33
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          flush,
    // fill side
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    // drain side
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data
);

    typedef struct packed {
        logic [1:0][W-1:0] ent;
        logic              rd;
        logic              wr;
        logic [1:0]        count;
    } buf_state_s;

    buf_state_s st_r;
    buf_state_s st_nxt;
    logic       push;
    logic       pop;

    // handshakes are combinational, data comes from the entry flops
    assign in_ready  = (st_r.count != 2'h2);
    assign out_valid = (st_r.count != 2'h0);
    assign out_data  = st_r.ent[st_r.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer and count update; push and pop may share a cycle
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.ent[st_r.wr] = in_data;
            st_nxt.wr           = ~st_r.wr;
        end
        if (pop) begin
            st_nxt.rd = ~st_r.rd;
        end
        st_nxt.count = st_r.count + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            st_nxt.rd    = 1'b0;
            st_nxt.wr    = 1'b0;
            st_nxt.count = 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

// [src/pipelined_burst_sram_port.sv]
// What this block does
// RQ1: sleep request is asynchronous, never sampled as a cycle input; high means sleep.
// RQ2: entering and leaving sleep each take two clock cycles.
// RQ3: sleep keeps stored words; an access pending at sleep entry may be lost.
// RQ4: controller deselects the memory before raising sleep request.
// RQ5: after sleep drops, controller keeps selects and strobes inactive two clocks.
// RQ6: mode high gives interleaved order: start bits xor step count.
// RQ7: mode low gives linear order: low bits increment, wrapping 11 to 00.
// RQ8: strobe with inactive select deselects; data pins go high impedance.
// RQ9: while sleep request is high, ignore inputs and float data pins.
// RQ10: selected processor strobe starts a read burst at external address.
// RQ11: controller strobe alone starts burst; write if write term active, else read.
// RQ12: writes only after a processor strobe start or with controller strobe start.
// RQ13: no strobe and advance low steps to next burst address.
// RQ14: no strobe and advance high repeats access at current address.
// RQ15: write term is global write low, or lane enable low with a lane low.
// RQ16: write updates only selected lanes; global write stores all four.
// RQ17: output enable acts asynchronously, masked in writes, drives only when selected.
// RQ18: controller raises output enable before a write starts.
// RQ19: read data appears after the following rising edge, through output register.
// RQ20: processor strobe write ignores write inputs first cycle, second edge decides.
// RQ21: first cycle after leaving deselect keeps data pins high impedance.
// RQ22: bursts wrap within four addresses set by the upper address bits.
`timescale 1ns/1ps
`default_nettype none

`include "sram_port_defs.svh"

module pipelined_burst_sram_port (
    // clock and reset
    input  wire logic                                CLOCK,
    input  wire logic                                RST_N,
    // address and selects
    input  wire logic [`ADDR_W-1:0]                  ADDRESS,
    input  wire logic                                CHIP_SELECT1_N,
    input  wire logic                                CHIP_SELECT2,
    input  wire logic                                CHIP_SELECT3_N,
    // burst control
    input  wire logic                                PROCESSOR_ADDR_STROBE_N,
    input  wire logic                                CONTROLLER_ADDR_STROBE_N,
    input  wire logic                                BURST_ADVANCE_N,
    input  wire logic                                MODE,
    // write control
    input  wire logic                                GLOBAL_WRITE_N,
    input  wire logic                                LANE_WRITE_ENABLE_N,
    input  wire logic [`LANES-1:0]                   BYTE_LANE_SELECT_N,
    // data pins and output enable
    input  wire logic                                OUTPUT_ENABLE_N,
    input  wire logic [`DATA_W-1:0]                  DQ_IN,
    output logic [`DATA_W-1:0]                       DQ_OUT,
    output logic                                     DQ_OE,
    // sleep
    input  wire logic                                SLEEP_REQUEST
);

    import sram_port_pkg::*;

    port_state_s          st_r;
    port_state_s          st_nxt;
    logic [`DATA_W-1:0]   mem [0:`WORDS-1];

    logic                 sel;
    logic                 processor_addr_strobe_n_act;
    logic                 write_term;
    logic                 start_p;
    logic                 start_c;
    logic                 start;
    logic                 desel;
    logic                 cont;
    logic                 awake;
    logic                 access_cont;
    logic                 mem_we;
    logic                 rd_launch;
    logic [`BURST_W-1:0]  step_n;
    logic [`BURST_W-1:0]  low;
    logic [`ADDR_W-1:0]   eff_addr;
    logic [`LANES-1:0]    lane_we;
    logic                 buf_in_ready;
    logic                 buf_out_valid;
    rd_word_s             buf_in;
    rd_word_s             head;

    // cycle decode from the sampled pins
    always_comb begin
        sel        = ~CHIP_SELECT1_N & CHIP_SELECT2 & ~CHIP_SELECT3_N;
        // processor strobe counts only while the primary select is low
        processor_addr_strobe_n_act   = ~PROCESSOR_ADDR_STROBE_N & ~CHIP_SELECT1_N;
        write_term = ~GLOBAL_WRITE_N
                   | (~LANE_WRITE_ENABLE_N & ~(&BYTE_LANE_SELECT_N));  // RQ15
        start_p    = processor_addr_strobe_n_act & sel;                                   // RQ10
        start_c    = ~CONTROLLER_ADDR_STROBE_N & ~processor_addr_strobe_n_act & sel;      // RQ11
        desel      = (processor_addr_strobe_n_act | ~CONTROLLER_ADDR_STROBE_N) & ~sel;    // RQ8
        cont       = CONTROLLER_ADDR_STROBE_N & ~processor_addr_strobe_n_act;
        // a full read buffer stalls new cycles; asleep ignores all pins
        awake       = ~st_r.asleep & buf_in_ready;                     // RQ9
        start       = awake & (start_p | start_c);
        access_cont = awake & cont & st_r.burst_active;
    end

    // burst address: step count kept apart from the start bits
    always_comb begin
        step_n = BURST_ADVANCE_N ? st_r.step : st_r.step + 2'h1;       // RQ13 RQ14
        if (MODE) begin
            low = st_r.base ^ step_n;                                  // RQ6
        end else begin
            low = st_r.base + step_n;                                  // RQ7
        end
        // upper bits never move, so the burst wraps in its group
        eff_addr = start ? ADDRESS : {st_r.upper, low};                // RQ22
    end

    // write and read launch; processor strobe start never writes
    always_comb begin
        mem_we    = awake & write_term & (start_c | access_cont);      // RQ12 RQ20
        rd_launch = awake & ~write_term & (start_c | access_cont)
                  | awake & start_p;                                   // RQ10 RQ11
        lane_we   = GLOBAL_WRITE_N ? ~BYTE_LANE_SELECT_N : 4'hf;       // RQ16
    end

    // next state
    always_comb begin
        st_nxt = st_r;
        // two-flop crossing: the first flop is read only by the second
        st_nxt.sync1  = SLEEP_REQUEST;                                 // RQ1
        st_nxt.asleep = st_r.sync1;                                    // RQ2
        if (start) begin
            st_nxt.upper        = ADDRESS[`ADDR_W-1:`BURST_W];
            st_nxt.base         = ADDRESS[`BURST_W-1:0];
            st_nxt.step         = `STEP_RESET;
            st_nxt.burst_active = 1'b1;
            st_nxt.deselected   = 1'b0;
        end else if (access_cont) begin
            st_nxt.step = step_n;
        end
        if (awake & desel) begin
            st_nxt.burst_active = 1'b0;
            st_nxt.deselected   = 1'b1;                                // RQ8
        end
        st_nxt.addr_r   = (start | access_cont) ? eff_addr : st_r.addr_r;
        st_nxt.rd_go    = rd_launch;
        // a read leaving the deselected state shows nothing at first
        st_nxt.rd_drive = rd_launch & ~(start & st_r.deselected);      // RQ21
        // pending work is dropped on sleep; the array itself is untouched
        if (st_r.asleep) begin
            st_nxt.burst_active = 1'b0;                                // RQ3
            st_nxt.deselected   = 1'b1;
            st_nxt.rd_go        = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_r            <= '0;
            st_r.deselected <= 1'b1;
            st_r.base       <= `BASE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // array write by lane; no reset, contents survive sleep
    always_ff @(posedge CLOCK) begin
        for (int i = 0; i < `LANES; i++) begin
            if (mem_we && lane_we[i]) begin
                mem[eff_addr][i*8 +: 8] <= DQ_IN[i*8 +: 8];            // RQ16
            end
        end
    end

    // array output for the read captured at the previous edge
    always_comb begin
        buf_in.drive = st_r.rd_drive;
        buf_in.data  = mem[st_r.addr_r];
    end

    // the buffer head is the output register of the read path
    read_buffer #(
        .W ($bits(rd_word_s))
    ) u_rdbuf (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .flush     (st_r.asleep),
        .in_valid  (st_r.rd_go),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (buf_out_valid),
        .out_ready (~st_r.asleep),
        .out_data  (head)
    );

    assign DQ_OUT = head.data;                                         // RQ19

    // pin enable: output enable and sleep act without the clock
    assign DQ_OE = buf_out_valid & head.drive & ~OUTPUT_ENABLE_N
                 & ~st_r.deselected & ~mem_we
                 & ~SLEEP_REQUEST & ~st_r.asleep;                      // RQ17 RQ9

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_sleep_high;
        SLEEP_REQUEST ##1 SLEEP_REQUEST;
    endsequence

    sequence s_sleep_low;
        !SLEEP_REQUEST ##1 !SLEEP_REQUEST;
    endsequence

    sequence s_shown_read;
        ##2 (buf_out_valid && head.drive);
    endsequence

    a_sleep_entry: assert property (s_sleep_high |=> st_r.asleep)  // RQ2
        else $error("sleep not entered two cycles after request");

    a_sleep_exit: assert property (s_sleep_low |=> !st_r.asleep)  // RQ2
        else $error("sleep not left two cycles after release");

    a_sleep_float: assert property (SLEEP_REQUEST |-> !DQ_OE)  // RQ9
        else $error("data pins driven while sleep requested");

    a_sleep_keeps: assert property (st_r.asleep |-> !mem_we && !st_nxt.burst_active)  // RQ3
        else $error("array written or burst kept while asleep");

    a_read_shown: assert property (
        (start_p && awake && !st_r.deselected) |-> s_shown_read)  // RQ10
        else $error("read data not at output two edges after start");

    a_first_float: assert property (
        (start && st_r.deselected && !st_r.asleep) |-> ##2 !DQ_OE)  // RQ21
        else $error("data pins driven in first cycle after deselect");

    a_deselect_float: assert property ((awake && desel) |=> !DQ_OE)  // RQ8
        else $error("data pins driven after deselect");

    a_proc_no_write: assert property (start_p |-> !mem_we)  // RQ12
        else $error("write in processor strobe start cycle");

    a_linear_step: assert property (
        (access_cont && !BURST_ADVANCE_N && !MODE)
        |=> st_r.addr_r[1:0] == $past(st_r.addr_r[1:0]) + 2'h1)  // RQ7
        else $error("linear burst did not step by one");

    a_interleave_step: assert property (
        (access_cont && !BURST_ADVANCE_N && MODE)
        |=> (st_r.addr_r[1:0] ^ st_r.base) == st_r.step)  // RQ6
        else $error("interleaved burst address wrong");

    a_suspend_hold: assert property (
        (access_cont && BURST_ADVANCE_N) |=> $stable(st_r.addr_r))  // RQ14
        else $error("suspended burst changed address");

    a_burst_group: assert property (
        access_cont |=> $stable(st_r.addr_r[`ADDR_W-1:`BURST_W]))  // RQ22
        else $error("burst left its four-address group");

    a_write_mask: assert property (mem_we |-> !DQ_OE)  // RQ17
        else $error("data pins driven during write");

endmodule

`default_nettype wire

// [test/ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

// controller side of the pin bus: changes pins just after an edge
module ctrl_model (
    // clock
    input  wire logic        clk,
    // address, selects and strobes
    output logic [18:0]      addr,
    output logic             cs1_n,
    output logic             cs2,
    output logic             cs3_n,
    output logic             pstb_n,
    output logic             cstb_n,
    output logic             adv_n,
    // write control and output enable
    output logic             gw_n,
    output logic             bwe_n,
    output logic [3:0]       bl_n,
    output logic             oe_n,
    // resolved data wire
    output logic [31:0]      dq_in,
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe
);
    logic [31:0] d_r;
    logic [31:0] last_r = '0;
    logic        wr;

    // no pull on the wire, so a floating bus shows the inverse of its last level
    assign wr    = oe_n & (~gw_n | (~bwe_n & ~&bl_n));
    assign dq_in = dq_oe ? dq_out : (wr ? d_r : ~last_r);

    // remember the wire level for the floating case
    always @(posedge clk) last_r <= dq_in;

    // one bus cycle, held until the next edge; x frees the selects of a continue
    task automatic drive(input logic [6:0] c, input logic [3:0] b,
                         input logic [18:0] a, input logic [31:0] d, input logic x);
        logic [3:0] r;
        r = 4'($urandom);
        @(posedge clk);
        // a high primary select hides the processor strobe, so it may go low then
        cs1_n  <= (x | (~c[6] & c[5])) & r[0];
        cs2    <= x ? r[1] : c[6];
        cs3_n  <= x ? r[2] : ~c[6];
        pstb_n <= c[5] & ~(x & r[0] & r[3]);
        cstb_n <= c[4];
        adv_n  <= c[3];
        gw_n   <= c[2];
        bwe_n  <= c[1];
        oe_n   <= c[0] | ~c[2] | (~c[1] & ~&b);
        bl_n   <= b;
        addr   <= a;
        d_r    <= d;
    endtask

    // quiet, deselected bus at time zero
    initial begin
        {cs1_n, cs2, cs3_n, pstb_n, cstb_n, adv_n, gw_n, bwe_n, oe_n} = 9'h07f;
        bl_n = 4'hf;
        addr = '0;
        d_r = '0;
    end
endmodule

`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // one read word on its way to the pins
    typedef struct packed {
        logic        v;
        logic        oe;
        logic        ds;
        logic        kn;
        logic [31:0] d;
    } exp_s;

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        mode = 1'b1;
    logic        sleep = 1'b0;
    logic        fresh = 1'b1;
    logic        bon = 1'b0;
    int          mismatches = 0;
    int          compares = 0;
    exp_s        iss = '0;
    exp_s        p1 = '0;
    exp_s        p2 = '0;
    logic [31:0] mem [int];
    logic [18:0] addr;
    logic [31:0] dq_in, dq_out;
    logic [3:0]  bl_n;
    logic        cs1_n, cs2, cs3_n, pstb_n, cstb_n, adv_n, gw_n, bwe_n, oe_n, dq_oe;

    always #4 clock = ~clock;

    ctrl_model DRV (.clk(clock), .addr(addr), .cs1_n(cs1_n), .cs2(cs2), .cs3_n(cs3_n),
        .pstb_n(pstb_n), .cstb_n(cstb_n), .adv_n(adv_n), .gw_n(gw_n), .bwe_n(bwe_n),
        .bl_n(bl_n), .oe_n(oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    pipelined_burst_sram_port DUT (.CLOCK(clock), .RST_N(rst_n), .ADDRESS(addr),
        .CHIP_SELECT1_N(cs1_n), .CHIP_SELECT2(cs2), .CHIP_SELECT3_N(cs3_n),
        .PROCESSOR_ADDR_STROBE_N(pstb_n), .CONTROLLER_ADDR_STROBE_N(cstb_n),
        .BURST_ADVANCE_N(adv_n), .MODE(mode), .GLOBAL_WRITE_N(gw_n),
        .LANE_WRITE_ENABLE_N(bwe_n), .BYTE_LANE_SELECT_N(bl_n), .OUTPUT_ENABLE_N(oe_n),
        .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .SLEEP_REQUEST(sleep));

    // address after s steps of a burst begun at a
    function automatic logic [18:0] baddr(input logic [18:0] a, input int s,
                                          input logic m);
        logic [1:0] k;
        k = s[1:0];
        return {a[18:2], m ? (a[1:0] ^ k) : (a[1:0] + k)};
    endfunction

    // stored word after a write; w is global write, lane enable
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [1:0] w, input logic [3:0] b);
        for (int i = 0; i < 4; i++) begin
            if (!w[1] || (!w[0] && !b[i])) o[8*i +: 8] = d[8*i +: 8];
        end
        return o;
    endfunction

    task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t data %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_oe(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t drive %b exp %b", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // a word sampled at edge t shows between t+1 and t+2; a deselect masks it at once
    always @(posedge clock) begin
        if (rst_n && p2.v && p2.kn && !p1.ds && !sleep) chk_d(dq_out, p2.d);
        if (rst_n) chk_oe(dq_oe, p2.v & p2.oe & ~p1.ds & ~oe_n & ~sleep);
        p1 <= iss;
        p2 <= p1;
    end

    // one bus cycle; c is select, both strobes, advance, global, lane enable, oe
    task automatic op(input logic [6:0] c, input logic [3:0] b,
                      input logic [18:0] a, input logic [31:0] d);
        exp_s        e;
        logic        st;
        logic [31:0] w;
        e = '0;
        st = c[6] & ~(c[5] & c[4]);
        w = mem.exists(a) ? mem[a] : 'x;
        DRV.drive(c, b, st ? a : 19'($urandom), d, bon & c[6] & c[5] & c[4]);
        if (!sleep && !c[6] && !(c[5] && c[4])) begin
            e.ds = 1'b1;
            fresh = 1'b1;
            bon = 1'b0;
        end else if (!sleep && (st || bon)) begin
            bon = 1'b1;
            if (c[5] && (!c[2] || (!c[1] && !(&b)))) mem[a] = merge(w, d, c[2:1], b);
            else e = '{1'b1, !fresh, 1'b0, !$isunknown(w), w};
            // any access, a write too, ends the deselected state
            fresh = 1'b0;
        end
        iss <= e;
    endtask

    // prime a group with global writes, then random lane writes and reads in it
    task automatic fill(input logic [18:0] a);
        for (int i = 0; i < 8; i++) begin
            op(i < 4 ? 7'h6b : {4'b1101, 1'($urandom % 4 != 0), 1'($urandom), 1'b1},
               4'($urandom), {a[18:2], i < 4 ? 2'(i) : 2'($urandom)}, $urandom);
        end
    endtask

    // deselect, start by either strobe, then steps and suspends
    task automatic burst(input logic [18:0] a, input logic m, input logic pc, input int n);
        int   s;
        logic burst_advance_n;
        s = 0;
        op(7'h2f, 4'hf, a, 32'h0);
        mode <= m;
        op(pc ? {2'b10, 5'($urandom)} : {4'b1101, 2'b10, 1'($urandom)},
           pc ? 4'($urandom) : 4'hf, a, $urandom);
        for (int i = 1; i < n; i++) begin
            burst_advance_n = 1'($urandom % 4 == 0);
            if (!burst_advance_n) s++;
            op({3'b111, burst_advance_n, 2'b11, 1'($urandom % 3 == 0)}, 4'hf, baddr(a, s, m), 0);
        end
    endtask

    // write behind a processor start: start ignores writes, then next and same address
    task automatic pwrite(input logic [18:0] a, input logic m);
        op(7'h2f, 4'hf, a, 32'h0);
        mode <= m;
        op(7'h53, 4'h0, a, $urandom);
        op(7'h73, 4'hf, baddr(a, 1, m), $urandom);
        op(7'h7d, 4'($urandom), baddr(a, 1, m), $urandom);
    endtask

    // main sequence
    initial begin
        void'($urandom(93046));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            logic [18:0] a;
            a = 19'($urandom);
            fill(a);
            if (i % 6 == 5) pwrite(a, i[0]);
            burst(a, i[0], i[1], 7);
        end
        fill(19'h4);
        op(7'h2f, 4'hf, 19'h0, 32'h0);
        sleep <= 1'b1;
        repeat (3) op(7'h3f, 4'hf, 19'h0, 32'h0);
        op(7'h6b, 4'h0, 19'h4, $urandom);
        sleep <= 1'b0;
        repeat (2) op(7'h3f, 4'hf, 19'h0, 32'h0);
        burst(19'h4, 1'b0, 1'b1, 5);
        repeat (3) op(7'h2f, 4'hf, 19'h0, 32'h0);
        end_sim;
    end

    // watchdog, far beyond the about 440 cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_sim;
    end
endmodule

`default_nettype wire
